//--- hw/ssp_pkg.sv
package ssp_pkg;
    // port mode select encodings
    localparam logic [3:0] MODE_DIV4 = 4'h0;
    localparam logic [3:0] MODE_DIV16 = 4'h1;
    localparam logic [3:0] MODE_DIV64 = 4'h2;
    localparam logic [3:0] MODE_SLV_SS = 4'h4;
    localparam logic [3:0] MODE_SLV = 4'h5;
    localparam logic [3:0] MODE_BAUD = 4'hA;
    // half periods of the serial clock, in core cycles
    localparam logic [9:0] HALF_DIV4 = 10'h002;
    localparam logic [9:0] HALF_DIV16 = 10'h008;
    localparam logic [9:0] HALF_DIV64 = 10'h020;
    localparam logic [9:0] HALF_BAUD_ADD = 10'h002;
    // byte framing and reset values
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [4:0] LAST_PHASE = 5'h10;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [2:0] PIN_RST = 3'h1;
    // status register layout
    localparam int STAT_BF_POS = 0;
    localparam int STAT_CKE_POS = 6;
    localparam int STAT_SMP_POS = 7;

    // control register one fields
    typedef struct packed {
        logic enable;
        logic clk_idle_high;
        logic [3:0] port_mode_select;
    } ssp_ctrl_one_t;

    // writable upper status bits
    typedef struct packed {
        logic sample_end;
        logic clk_edge_sel;
    } ssp_stat_cfg_t;

    // master modes drive the serial clock
    function automatic logic ssp_is_master(input logic [3:0] m);
        return (m[3:2] == 2'b00) || (m == MODE_BAUD);
    endfunction

    // slave modes take the serial clock from outside
    function automatic logic ssp_is_slave(input logic [3:0] m);
        return (m == MODE_SLV_SS) || (m == MODE_SLV);
    endfunction
endpackage

//--- hw/ssp_sync.sv
`timescale 1ns/1ps
module ssp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_core_clk,        // core clock
    input wire logic i_reset_n,         // async reset, active low
    input wire logic [W-1:0] i_async,   // pin levels
    output logic [W-1:0] o_sync         // synchronised levels
);
    logic [W-1:0] meta_ff;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_ff <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_ff <= i_async;
            o_sync <= meta_ff;
        end
    end
endmodule

//--- hw/ssp_clk_div.sv
`timescale 1ns/1ps
module ssp_clk_div #(
    parameter int CW = 10
) (
    input wire logic i_core_clk,        // core clock
    input wire logic i_reset_n,         // async reset, active low
    input wire logic i_run,             // count while high
    input wire logic [CW-1:0] i_half,   // cycles per tick, at least 2
    output logic o_tick                 // one-cycle enable pulse
);
    logic [CW-1:0] cnt_ff;

    if (CW < 2) begin : g_bad_width
        $error("ssp_clk_div: CW must be at least 2");
    end

    // free count restarted whenever the engine stops
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_ff <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_ff <= '0;
            o_tick <= 1'b0;
        end else if (cnt_ff == i_half - 1'b1) begin
            cnt_ff <= '0;
            o_tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule

//--- hw/ssp_spi_port.sv
`timescale 1ns/1ps
// Contract
// (RULE_01) eight-bit shift, MSb out, LSb in
// (RULE_02) data changes one edge, sampled on other
// (RULE_03) master clocks; both share idle polarity
// (RULE_04) full byte copies to buffer, sets flags
// (RULE_05) receive path is double-buffered
// (RULE_06) write loads buffer and shifter; master starts
// (RULE_07) write while shifting dropped, sets collision
// (RULE_08) buffer read clears buffer-full flag
// (RULE_09) software reads buffer before next write
// (RULE_10) shifter reachable only through data buffer
// (RULE_11) control bits pick mode, clock, phase, rate
// (RULE_12) status low bits read-only, top two writable
// (RULE_13) master drives clock; slave takes clock
// (RULE_14) port works only while enabled
// (RULE_15) baud value feeds the rate generator
// (RULE_16) master selects one slave at a time; the port has no select output
// (RULE_17) master stops clock, deselects when done; the port stops its clock but has no select output
// (RULE_18) unselected slave ignores bus, drives nothing
// (RULE_19) master rate: /4, /16, /64, /(4(b+1))
// (RULE_20) select release floats data out at once
// (RULE_21) port reset clears the bit counter
// (RULE_22) disabled port holds reset, releases pins
module ssp_spi_port (
    input wire logic i_core_clk,                        // core clock, 10 MHz
    input wire logic i_reset_n,                         // async reset, active low
    input wire ssp_pkg::ssp_ctrl_one_t i_port_control_one, // enable, polarity, mode
    input wire ssp_pkg::ssp_stat_cfg_t i_stat_cfg,      // sample phase, clock edge
    input wire logic [7:0] i_baud_rate_value,           // baud generator reload
    input wire logic i_buf_wr,                          // data buffer write strobe
    input wire logic [7:0] i_buf_wdata,                 // data buffer write data
    input wire logic i_buf_rd,                          // data buffer read strobe
    input wire logic i_irq_clear,                       // clears the interrupt flag
    input wire logic i_write_collision_flag_clear,                      // clears the collision flag
    output logic [7:0] o_port_data_buffer,              // received / written byte
    output logic [7:0] o_port_status_reg,               // status register image
    output logic o_buffer_full_flag,                    // received byte waiting
    output logic o_port_irq_flag,                       // byte complete event
    output logic o_write_collision_flag,                // write was dropped
    input wire logic i_sck,                             // serial clock pin in
    output logic o_sck,                                 // serial clock pin out
    output logic o_sck_oe,                              // drive serial clock
    input wire logic i_sdi,                             // serial data in pin
    output logic o_sdo,                                 // serial data out pin
    output logic o_sdo_oe,                              // drive serial data out
    input wire logic i_ss_n                             // slave select pin, low
);
    typedef enum logic {SH_IDLE, SH_ACTIVE} ssp_state_t;

    ssp_state_t state_ff;
    logic [2:0] pins;
    logic s_sck, s_sdi, s_ss_n;
    logic sck_d_ff, sck_lvl_ff, pend_ff, tick;
    logic [4:0] phase_ff;
    logic [3:0] bitcnt_ff;
    logic [7:0] shreg_ff, buf_ff;
    logic sdo_ff, bf_ff, irq_ff, write_collision_flag_ff;
    logic master, slave, en_ok, slave_sel, ss_rst, busy, wr_ok, coll;
    logic lead_e, trail_e, chg_e, raw_smp_e, sample_e, done;
    logic cap_e;
    logic [2:0] cap_dly_ff;
    logic [7:0] rx_byte;
    logic [9:0] half;
    logic [3:0] mode;
    logic ckp, cke, smp;

    // pin synchronisers
    ssp_sync #(.W(3), .RST_VAL(ssp_pkg::PIN_RST)) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_sck, i_sdi, i_ss_n}),
        .o_sync(pins)
    );
    assign {s_sck, s_sdi, s_ss_n} = pins;

    // configuration decode
    assign mode = i_port_control_one.port_mode_select; // RULE_11
    assign ckp = i_port_control_one.clk_idle_high; // RULE_11
    assign cke = i_stat_cfg.clk_edge_sel; // RULE_11
    assign smp = i_stat_cfg.sample_end & master; // RULE_11
    assign master = ssp_pkg::ssp_is_master(mode); // RULE_13
    assign slave = ssp_pkg::ssp_is_slave(mode); // RULE_13
    assign en_ok = i_port_control_one.enable & (master | slave); // RULE_14
    assign slave_sel = slave & ((mode != ssp_pkg::MODE_SLV_SS) | ~s_ss_n); // RULE_18
    assign ss_rst = (mode == ssp_pkg::MODE_SLV_SS) & s_ss_n; // RULE_21
    assign busy = (bitcnt_ff != 4'h0) | (state_ff == SH_ACTIVE);
    assign wr_ok = i_buf_wr & en_ok & ~write_collision_flag_ff & ~busy; // RULE_06
    assign coll = i_buf_wr & en_ok & ~write_collision_flag_ff & busy; // RULE_07

    // serial clock rate selection
    always_comb begin
        case (mode)
            ssp_pkg::MODE_DIV16: half = ssp_pkg::HALF_DIV16; // RULE_19
            ssp_pkg::MODE_DIV64: half = ssp_pkg::HALF_DIV64; // RULE_19
            ssp_pkg::MODE_BAUD: half = {1'b0, i_baud_rate_value, 1'b0} + ssp_pkg::HALF_BAUD_ADD; // RULE_15
            default: half = ssp_pkg::HALF_DIV4; // RULE_19
        endcase
    end

    // half-period ticks for the master clock
    ssp_clk_div #(.CW(10)) u_div (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_run(en_ok & master & (state_ff == SH_ACTIVE)),
        .i_half(half),
        .o_tick(tick)
    );

    // edge detection, master from its own ticks, slave from the pin
    always_comb begin
        if (master) begin
            lead_e = tick & (phase_ff < ssp_pkg::LAST_PHASE) & ~phase_ff[0];
            trail_e = tick & (phase_ff < ssp_pkg::LAST_PHASE) & phase_ff[0];
        end else begin
            lead_e = en_ok & slave_sel & (s_sck != sck_d_ff) & (s_sck != ckp); // RULE_18
            trail_e = en_ok & slave_sel & (s_sck != sck_d_ff) & (s_sck == ckp); // RULE_18
        end
    end
    assign chg_e = cke ? trail_e : lead_e; // RULE_02
    assign raw_smp_e = cke ? lead_e : trail_e; // RULE_02
    assign sample_e = smp ? (tick & pend_ff) : raw_smp_e; // RULE_02
    // master input lags its sample edge by the pin round trip: clock out, two syncs
    assign cap_e = master ? cap_dly_ff[2] : sample_e; // RULE_02
    assign done = cap_e & (bitcnt_ff == ssp_pkg::LAST_BIT);
    // byte handed to the buffer, slave bits arrive with their shift
    assign rx_byte = sample_e ? {shreg_ff[6:0], s_sdi} : {shreg_ff[7:1], s_sdi}; // RULE_04

    // delayed sampling point for end-of-output-time sampling
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_ff <= 1'b0;
            sck_d_ff <= 1'b0;
        end else begin
            sck_d_ff <= s_sck;
            if (!en_ok || wr_ok) begin
                pend_ff <= 1'b0;
            end else if (raw_smp_e) begin
                pend_ff <= 1'b1;
            end else if (tick) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // capture delay line, cleared with the engine
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cap_dly_ff <= 3'h0;
        end else if (!en_ok || wr_ok) begin
            cap_dly_ff <= 3'h0; // RULE_22
        end else begin
            cap_dly_ff <= {cap_dly_ff[1:0], sample_e & master};
        end
    end

    // master clock sequencer, sixteen edges then one idle tick
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= SH_IDLE;
            phase_ff <= 5'h00;
            sck_lvl_ff <= 1'b0;
        end else begin
            case (state_ff)
                SH_IDLE: begin
                    phase_ff <= 5'h00;
                    sck_lvl_ff <= ckp; // RULE_03
                    if (wr_ok && master) begin
                        state_ff <= SH_ACTIVE; // RULE_06
                    end
                end
                SH_ACTIVE: begin
                    if (!en_ok) begin
                        state_ff <= SH_IDLE; // RULE_22
                    end else if (tick) begin
                        if (phase_ff == ssp_pkg::LAST_PHASE) begin
                            state_ff <= SH_IDLE;
                        end else begin
                            sck_lvl_ff <= ~sck_lvl_ff; // RULE_13
                            phase_ff <= phase_ff + 5'h01;
                        end
                    end
                end
                default: state_ff <= SH_IDLE;
            endcase
        end
    end

    // shift register and bit counter, hidden behind the data buffer
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin // RULE_10
        if (!i_reset_n) begin
            shreg_ff <= ssp_pkg::BUF_RST;
            bitcnt_ff <= 4'h0;
            sdo_ff <= 1'b0;
        end else if (!en_ok) begin
            shreg_ff <= ssp_pkg::BUF_RST; // RULE_22
            bitcnt_ff <= 4'h0; // RULE_21
            sdo_ff <= 1'b0;
        end else if (wr_ok) begin
            shreg_ff <= i_buf_wdata; // RULE_06
            sdo_ff <= i_buf_wdata[7]; // RULE_01
            bitcnt_ff <= 4'h0;
        end else if (ss_rst) begin
            bitcnt_ff <= 4'h0; // RULE_21
        end else begin
            if (sample_e) begin
                shreg_ff <= {shreg_ff[6:0], cap_e ? s_sdi : 1'b0}; // RULE_01
            end else if (cap_e) begin
                shreg_ff[0] <= s_sdi; // RULE_01 RULE_02
            end
            if (cap_e) begin
                bitcnt_ff <= done ? 4'h0 : bitcnt_ff + 4'h1; // RULE_01
            end
            if (chg_e) begin
                sdo_ff <= sample_e ? shreg_ff[6] : shreg_ff[7]; // RULE_02
            end
        end
    end

    // data buffer, loaded by software or by a finished byte
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            buf_ff <= ssp_pkg::BUF_RST;
        end else if (wr_ok) begin
            buf_ff <= i_buf_wdata; // RULE_06
        end else if (done) begin
            buf_ff <= rx_byte; // RULE_04 RULE_05
        end
    end

    // sticky flags, a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bf_ff <= 1'b0;
            irq_ff <= 1'b0;
            write_collision_flag_ff <= 1'b0;
        end else begin
            if (done) begin
                bf_ff <= 1'b1; // RULE_04
            end else if (i_buf_rd) begin
                bf_ff <= 1'b0; // RULE_08
            end
            if (done) begin
                irq_ff <= 1'b1; // RULE_04
            end else if (i_irq_clear) begin
                irq_ff <= 1'b0;
            end
            if (coll) begin
                write_collision_flag_ff <= 1'b1; // RULE_07
            end else if (i_write_collision_flag_clear) begin
                write_collision_flag_ff <= 1'b0;
            end
        end
    end

    // registered outputs and pin drivers
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sck <= 1'b0;
            o_sck_oe <= 1'b0;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
            o_port_status_reg <= 8'h00;
        end else begin
            o_sck <= sck_lvl_ff;
            o_sck_oe <= en_ok & master; // RULE_13 RULE_22
            o_sdo <= sdo_ff;
            o_sdo_oe <= en_ok & (master | slave_sel); // RULE_18 RULE_20 RULE_22
            o_port_status_reg <= 8'h00; // RULE_12
            o_port_status_reg[ssp_pkg::STAT_SMP_POS] <= i_stat_cfg.sample_end; // RULE_12
            o_port_status_reg[ssp_pkg::STAT_CKE_POS] <= i_stat_cfg.clk_edge_sel; // RULE_12
            o_port_status_reg[ssp_pkg::STAT_BF_POS] <= bf_ff; // RULE_12
        end
    end
    assign o_port_data_buffer = buf_ff;
    assign o_buffer_full_flag = bf_ff;
    assign o_port_irq_flag = irq_ff;
    assign o_write_collision_flag = write_collision_flag_ff;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    a_write_collision_flag_on_busy: assert property (coll |=> write_collision_flag_ff) // RULE_07
        else $error("collision flag not set by write while busy");
    a_busy_write_drop: assert property (coll && !done |=> buf_ff == $past(buf_ff)) // RULE_07
        else $error("write during shift changed the buffer");
    a_done_sets_flags: assert property (done |=> bf_ff && irq_ff) // RULE_04
        else $error("byte end did not set buffer-full and interrupt");
    a_done_captures: assert property (done |=> buf_ff == $past(rx_byte)) // RULE_05
        else $error("received byte not copied into buffer");
    a_read_clears: assert property (i_buf_rd && !done |=> !bf_ff) // RULE_08
        else $error("buffer read did not clear buffer-full");
    a_disable_reset: assert property (!en_ok |=> bitcnt_ff == 4'h0 && !o_sck_oe && !o_sdo_oe) // RULE_22
        else $error("disabled port not held in reset");
    a_ss_release: assert property (en_ok && ss_rst |=> bitcnt_ff == 4'h0 && !o_sdo_oe) // RULE_20
        else $error("slave select release did not float data out");
    a_master_start: assert property (wr_ok && master |=> state_ff == SH_ACTIVE) // RULE_06
        else $error("master write did not start the exchange");
    a_msb_first: assert property (wr_ok |=> sdo_ff == $past(i_buf_wdata[7])) // RULE_01
        else $error("first data bit is not the MSb");
    a_master_clk_oe: assert property (en_ok && master |=> o_sck_oe) // RULE_13
        else $error("master does not drive the serial clock");
    a_rx_count: assert property (cap_e && !done && en_ok && !ss_rst && !wr_ok // RULE_01
        |=> bitcnt_ff == $past(bitcnt_ff) + 4'h1)
        else $error("received bit not counted");
    a_capture_lag: assert property (master && en_ok && sample_e ##1 (master && en_ok) [*2] // RULE_02
        |=> cap_e)
        else $error("master input not captured three cycles after its sample edge");
endmodule

//--- testbench/ssp_far_end.sv
`timescale 1ns/1ps
// far end of the link: follows when the port leads, leads otherwise
module ssp_far_end #(
    parameter int HALF = 8
) (
    input wire logic i_core_clk,   // core clock
    input wire logic i_lead,       // far end leads
    input wire logic i_go,         // load byte, lead a frame
    input wire logic [3:0] i_bits, // bits per frame
    input wire logic i_nosel,      // clock with select high
    input wire logic [7:0] i_tx,   // byte to send
    input wire logic i_sck,        // clock on the wire
    input wire logic i_from_dev,   // data from the port
    output logic o_sck,            // clock when leading
    output logic o_ss_n,           // select when leading
    output logic o_to_dev,         // data to the port
    output logic [7:0] o_rx,       // byte taken in
    output logic o_busy            // leading a frame
);
    logic [7:0] sr;
    int n;
    // idle: clock low, deselected
    initial begin
        {o_sck, o_to_dev, o_busy, sr, o_rx} = '0;
        o_ss_n = 1'b1;
        n = 0;
    end
    // follower puts the next bit out on each rising edge
    always @(posedge i_sck) begin
        if (!i_lead && n < 8) begin
            o_to_dev <= sr[7];
        end
    end
    // follower samples on falling edges, line inverted once released
    always @(negedge i_sck) begin
        if (!i_lead) begin
            sr = {sr[6:0], i_from_dev};
            o_rx = sr;
            n++;
            if (n == 8) begin
                o_to_dev <= ~o_to_dev;
            end
        end
    end
    // leader: select, clock the bits, stop the clock and deselect
    always @(posedge i_core_clk) begin
        if (i_go) begin
            sr = i_tx;
            n = 0;
            if (i_lead) begin
                o_busy <= 1'b1;
                o_ss_n <= i_nosel;
                repeat (HALF) @(posedge i_core_clk);
                for (int k = 0; k < i_bits; k++) begin
                    o_sck <= 1'b1;
                    o_to_dev <= sr[7];
                    repeat (HALF) @(posedge i_core_clk);
                    o_sck <= 1'b0;
                    sr = {sr[6:0], i_from_dev};
                    repeat (HALF) @(posedge i_core_clk);
                end
                o_rx <= sr;
                o_ss_n <= 1'b1;
                o_to_dev <= ~o_to_dev;
                o_busy <= 1'b0;
            end
        end
    end
endmodule

//--- testbench/test_sync_serial_spi_port.sv
`timescale 1ns/1ps
module test_sync_serial_spi_port;
    logic i_core_clk, i_reset_n, wr, rd, irq_clr, write_collision_flag_clr, lead, go, nosel, last_sdo;
    logic bf, irq, write_collision_flag, sck_o, sck_oe, sdo, sdo_oe, f_sck, f_ss_n, f_data, f_busy;
    logic [7:0] baud, wdata, buf_q, stat_q, f_tx, f_rx;
    logic [3:0] nbits;
    logic [31:0] seed;
    ssp_pkg::ssp_ctrl_one_t ctl;
    ssp_pkg::ssp_stat_cfg_t cfg;
    int errors, comparisons;
    // wire levels: a released data line reads inverted
    wire logic sck_w = sck_oe ? sck_o : f_sck;
    wire logic sdo_w = sdo_oe ? sdo : ~last_sdo;

    ssp_spi_port dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_port_control_one(ctl),
        .i_stat_cfg(cfg), .i_baud_rate_value(baud), .i_buf_wr(wr), .i_buf_wdata(wdata),
        .i_buf_rd(rd), .i_irq_clear(irq_clr), .i_write_collision_flag_clear(write_collision_flag_clr),
        .o_port_data_buffer(buf_q), .o_port_status_reg(stat_q), .o_buffer_full_flag(bf),
        .o_port_irq_flag(irq), .o_write_collision_flag(write_collision_flag), .i_sck(sck_w), .o_sck(sck_o),
        .o_sck_oe(sck_oe), .i_sdi(f_data), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_ss_n(f_ss_n));
    ssp_far_end far (.i_core_clk(i_core_clk), .i_lead(lead), .i_go(go), .i_bits(nbits),
        .i_nosel(nosel), .i_tx(f_tx), .i_sck(sck_w), .i_from_dev(sdo_w), .o_sck(f_sck),
        .o_ss_n(f_ss_n), .o_to_dev(f_data), .o_rx(f_rx), .o_busy(f_busy));

    // core clock
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    // last driven data level
    always @(posedge i_core_clk) begin
        if (sdo_oe) begin
            last_sdo <= sdo;
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // serial clock half period in core cycles
    function automatic int half_of(logic [3:0] m, logic [7:0] b);
        case (m)
            ssp_pkg::MODE_DIV16: return 16 / 2;
            ssp_pkg::MODE_DIV64: return 64 / 2;
            ssp_pkg::MODE_BAUD: return 4 * (int'(b) + 1) / 2;
            default: return 4 / 2;
        endcase
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_flag(input string s, input logic e, input logic g);
        chk(s, {7'h00, e}, {7'h00, g});
    endtask
    // strobe: 0 read, 1 irq clear, 2 collision clear, 3 write
    task automatic strobe(input int k, input logic [7:0] d);
        case (k)
            0: rd <= 1'b1;
            1: irq_clr <= 1'b1;
            2: write_collision_flag_clr <= 1'b1;
            default: wr <= 1'b1;
        endcase
        wdata <= d;
        tk(1);
        {rd, irq_clr, write_collision_flag_clr, wr} <= 4'h0;
        tk(1);
    endtask
    // reconfigure with the port disabled, then enable
    task automatic set_mode(input logic [3:0] m);
        ctl <= '{1'b0, 1'b0, m};
        tk(2);
        ctl.enable <= 1'b1;
        tk(2);
    endtask
    task automatic far_go(input logic [7:0] d, input logic [3:0] b, input logic ns);
        f_tx <= d;
        nbits <= b;
        nosel <= ns;
        go <= 1'b1;
        tk(1);
        go <= 1'b0;
        tk(1);
    endtask
    // wait for the far frame or the event flag; first whole clock high phase
    task automatic wait_done(input logic far_side, output int hi);
        int run;
        int k;
        run = -1;
        hi = 0;
        for (k = 0; k < 3000 && (far_side ? f_busy !== 1'b0 : irq !== 1'b1); k++) begin
            tk(1);
            if (sck_o === 1'b1) begin
                if (run >= 0) run++;
            end else if (run > 0 && hi == 0) begin
                hi = run;
            end else if (run < 0) begin
                run = 0;
            end
        end
        if (k == 3000) begin
            errors++;
            close_out();
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        int hi;
        logic [31:0] r;
        logic [7:0] tx;
        logic [3:0] m;
        errors = 0;
        comparisons = 0;
        seed = 32'h0000_ba15;
        i_reset_n = 1'b0;
        {wr, rd, irq_clr, write_collision_flag_clr, lead, go, nosel, last_sdo} = 8'h00;
        {baud, wdata, f_tx} = 24'h00_0000;
        nbits = 4'h8;
        ctl = '0;
        cfg = '0;
        tk(4);
        chk_flag("clock drive in reset", 1'b0, sck_oe);
        chk_flag("data drive in reset", 1'b0, sdo_oe);
        i_reset_n <= 1'b1;
        tk(2);
        // master exchanges at every rate
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            m = i == 0 ? ssp_pkg::MODE_DIV4 : i == 1 ? ssp_pkg::MODE_DIV16 :
                i == 2 ? ssp_pkg::MODE_DIV64 : ssp_pkg::MODE_BAUD;
            baud <= {6'h00, r[1:0]};
            set_mode(m);
            tx = r[15:8];
            far_go(r[23:16], 4'h8, 1'b0);
            strobe(3, tx);
            if (i == 0) begin
                strobe(3, ~tx);
                tk(2);
                chk_flag("collision", 1'b1, write_collision_flag);
                chk("buffer kept", tx, buf_q);
            end
            wait_done(1'b0, hi);
            tk(2);
            chk("clock half period", 8'(half_of(m, baud)), 8'(hi));
            chk("received byte", r[23:16], buf_q);
            chk("far byte", tx, f_rx);
            chk("status", 8'h01, stat_q);
            strobe(1, 8'h00);
            if (i == 0) begin
                strobe(3, 8'h3c);
                tk(2);
                chk("buffer after refused write", r[23:16], buf_q);
                strobe(2, 8'h00);
                chk_flag("collision cleared", 1'b0, write_collision_flag);
            end
            if (i[0]) begin
                strobe(0, 8'h00);
                chk_flag("full after read", 1'b0, bf);
            end
        end
        // disable in mid-byte, then a clean exchange
        far_go(8'ha5, 4'h8, 1'b0);
        strobe(3, 8'h96);
        tk(20);
        ctl.enable <= 1'b0;
        tk(4);
        chk_flag("clock released", 1'b0, sck_oe);
        chk_flag("data released", 1'b0, sdo_oe);
        cfg <= '{1'b1, 1'b1};
        tk(80);
        chk_flag("no event when disabled", 1'b0, irq);
        chk("status layout", 8'hc0, stat_q);
        cfg <= '0;
        far_go(8'h5a, 4'h8, 1'b0);
        ctl.enable <= 1'b1;
        tk(2);
        strobe(3, 8'h69);
        wait_done(1'b0, hi);
        tk(2);
        chk("byte after enable", 8'h5a, buf_q);
        chk("far byte after enable", 8'h69, f_rx);
        strobe(1, 8'h00);
        // slave: aborted, full, unselected, then without select
        lead <= 1'b1;
        set_mode(ssp_pkg::MODE_SLV_SS);
        for (int j = 0; j < 4; j++) begin
            r = rnd();
            if (j == 3) set_mode(ssp_pkg::MODE_SLV);
            strobe(3, r[7:0]);
            far_go(r[15:8], j == 0 ? 4'h4 : 4'h8, j > 1);
            wait_done(1'b1, hi);
            tk(6);
            chk_flag("slave event", j[0], irq);
            if (j[0]) begin
                chk("slave received", r[15:8], buf_q);
                chk("far received", r[7:0], f_rx);
                strobe(1, 8'h00);
                strobe(0, 8'h00);
            end else begin
                chk_flag("data floated", 1'b0, sdo_oe);
            end
        end
        close_out();
    end
endmodule
